// *** common/edp_regs.vh ***
// Purpose: Register map, field positions and reset values for the EEPROM row programmer
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register, 8-bit byte address
// Notes:   Operation list below; tags appear in rtl/edp_eeprom_exec.v
//
// Operation
// - EEPROM panel is up to 128 rows of sixteen 16-bit words.
// - At most one panel; size 512, 1024 or 2048 words (32/64/128 rows).
// - EEPROM array is written only by a row-program command, one row each.
// - Seven 16-bit nonvolatile configuration registers, every bit settable and clearable.
// - System bits set power-on oscillator state; code-protect blocks program memory access.
// - Clock-switch field: 1x none, 01 switching only, 00 switching plus fail-safe.
// - Oscillator source: 11 primary, 10 low-power RC, 01 fast RC, 00 32 kHz.
// - Primary mode: 1111 ext clock x16 pin I/O, 1000 ext RC I/O, 0111 crystal x16.
// - Oscillator word layout has three device variants; other words are fixed. The code decodes only the variant 0 layout.
// - Row-program writes the addressed row, then verifies it before reporting completion.
`ifndef EDP_REGS_VH
`define EDP_REGS_VH

// Byte offsets
`define EDP_OFF_CMD      8'h00
`define EDP_OFF_ADDR     8'h04
`define EDP_OFF_STATUS   8'h08
`define EDP_OFF_RDATA    8'h0C
`define EDP_OFF_OSCDEC   8'h10
`define EDP_BASE_ROWBUF  2'h1
`define EDP_BASE_CFG     3'h4
`define EDP_CFG_COUNT    3'h7

// Command bits
`define EDP_CMD_ROW_WRITE 0
`define EDP_CMD_READBACK  1
// Status bits
`define EDP_ST_BUSY 0
`define EDP_ST_DONE 1
`define EDP_ST_FAIL 2

// Geometry
`define EDP_WORDS_PER_ROW 16
`define EDP_ROW_SHIFT     5

// Oscillator word field positions (variant 0)
`define EDP_CLK_SW_HI   15
`define EDP_CLK_SW_LO   14
`define EDP_OSC_SRC_HI  9
`define EDP_OSC_SRC_LO  8
`define EDP_PRI_MODE_HI 3
`define EDP_PRI_MODE_LO 0
// Code-protect bit, held in the last configuration word
`define EDP_CP_WORD  3'h6
`define EDP_CP_BIT   0

// Erased state of nonvolatile cells
`define EDP_ERASED  16'hFFFF
`define EDP_RESP_OK  2'h0
`define EDP_RESP_ERR 2'h2

`endif

// *** rtl/edp_eeprom_exec.v ***
// Purpose: Programming executive for the data EEPROM row program, read-back and config words
// Assumes: AXI4-Lite slave, single clock, synchronous active-low reset
// Notes:   Storage is flip-flops; configuration words start in the erased state
`timescale 1ns/1ns
`default_nettype none
`include "edp_regs.vh"

module edp_eeprom_exec #(
  parameter ROWS        = 128,
  parameter OSC_VARIANT = 0
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         cfg_clk_switch_en,
  output reg         cfg_fail_safe_en,
  output reg  [1:0]  cfg_osc_source,
  output reg         cfg_external_clock_pin_io,
  output reg         cfg_external_rc_pin_io,
  output reg         cfg_crystal_mid_range_mode,
  output reg         cfg_prog_mem_lock
);

  localparam WORDS = ROWS * `EDP_WORDS_PER_ROW;
  localparam AW    = $clog2(WORDS);
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_WR   = 4'h2;
  localparam [3:0] S_VF   = 4'h4;
  localparam [3:0] S_DN   = 4'h8;

  // Address decode shared by the read and write paths
  function map_ok;
    input [7:0] a;
    begin
      map_ok = (a[1:0] == 2'h0) &&
               ((a <= `EDP_OFF_OSCDEC) || (a[7:6] == `EDP_BASE_ROWBUF) ||
                ((a[7:5] == `EDP_BASE_CFG) && (a[4:2] < `EDP_CFG_COUNT)));
    end
  endfunction

  reg [15:0]   mem [0:WORDS-1];
  reg [15:0]   rowbuf_q [0:15];
  reg [15:0]   cfg_q [0:6];
  reg [15:0]   addr_q;
  reg [15:0]   rb_q;
  reg [3:0]    state_q;
  reg [3:0]    wcnt_q;
  reg          done_q;
  reg          fail_q;
  reg          mism_q;
  reg          aw_hold_q;
  reg          w_hold_q;
  reg [7:0]    awaddr_q;
  reg [31:0]   wdata_q;
  reg [3:0]    wstrb_q;

  wire [15:0]   row_idx   = addr_q >> `EDP_ROW_SHIFT;
  wire          addr_bad  = (row_idx >= ROWS) || (addr_q[4:0] != 5'h00);
  wire [AW-1:0] row_base  = addr_q[AW:1] & ~{{(AW-4){1'b0}}, 4'hF};
  wire [AW-1:0] word_idx  = row_base | {{(AW-4){1'b0}}, wcnt_q};
  wire [AW-1:0] rb_idx    = addr_q[AW:1];
  wire          rb_bad    = (row_idx >= ROWS) || addr_q[0];
  wire          wr_go     = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire          wr_ok     = map_ok(awaddr_q);
  wire          cmd_wr    = wr_go && (awaddr_q == `EDP_OFF_CMD) && wstrb_q[0];
  wire          st_wr     = wr_go && (awaddr_q == `EDP_OFF_STATUS) && wstrb_q[0];
  wire          idle      = (state_q == S_IDLE);
  wire          start_row = cmd_wr && idle && wdata_q[`EDP_CMD_ROW_WRITE];
  wire          start_rb  = cmd_wr && idle && wdata_q[`EDP_CMD_READBACK];
  wire [15:0]   osc_w     = cfg_q[0];
  wire [3:0]    pri_mode  = osc_w[`EDP_PRI_MODE_HI:`EDP_PRI_MODE_LO];
  wire [15:0]   wmask     = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [15:0]   wmerge_b  = wdata_q[15:0] & wmask;
  integer i;

  // Row program sequencer: write the sixteen words, then read each back and compare
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      wcnt_q  <= 4'h0;
      mism_q  <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          wcnt_q <= 4'h0;
          mism_q <= 1'b0;
          if (start_row) begin
            state_q <= addr_bad ? S_DN : S_WR;
            mism_q  <= addr_bad;
          end
        end
        S_WR: begin
          wcnt_q <= wcnt_q + 4'h1;
          if (wcnt_q == 4'hF)
            state_q <= S_VF;
        end
        S_VF: begin
          wcnt_q <= wcnt_q + 4'h1;
          if (mem[word_idx] != rowbuf_q[wcnt_q])
            mism_q <= 1'b1;
          if (wcnt_q == 4'hF)
            state_q <= S_DN;
        end
        S_DN: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Array cells change only inside a row-program sequence
  always @(posedge aclk) begin
    if (state_q == S_WR)
      mem[word_idx] <= rowbuf_q[wcnt_q];
  end

  // Sticky completion flags; a new event beats a software clear in the same cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      done_q <= (state_q == S_DN) ||
                (done_q && !(st_wr && wdata_q[`EDP_ST_DONE])) ||
                start_rb;
      fail_q <= ((state_q == S_DN) && mism_q) || (start_rb && rb_bad) ||
                (fail_q && !(st_wr && wdata_q[`EDP_ST_FAIL]));
    end
  end

  // Software registers: address, row buffer, configuration words, read-back word
  always @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= 16'h0000;
      rb_q   <= 16'h0000;
      for (i = 0; i < 16; i = i + 1)
        rowbuf_q[i] <= 16'h0000;
      for (i = 0; i < 7; i = i + 1)
        cfg_q[i] <= `EDP_ERASED;
    end else begin
      if (start_rb && !rb_bad)
        rb_q <= mem[rb_idx];
      if (wr_go && idle && (awaddr_q == `EDP_OFF_ADDR))
        addr_q <= (addr_q & ~wmask) | wmerge_b;
      // Row buffer is frozen while a row is in flight so verify sees what was written
      if (wr_go && idle && (awaddr_q[7:6] == `EDP_BASE_ROWBUF))
        rowbuf_q[awaddr_q[5:2]] <= (rowbuf_q[awaddr_q[5:2]] & ~wmask) | wmerge_b;
      if (wr_go && wr_ok && (awaddr_q[7:5] == `EDP_BASE_CFG))
        cfg_q[awaddr_q[4:2]] <= (cfg_q[awaddr_q[4:2]] & ~wmask) | wmerge_b;
    end
  end

  // Power-on settings decoded from the configuration words
  always @(posedge aclk) begin
    if (!aresetn) begin
      cfg_clk_switch_en          <= 1'b0;
      cfg_fail_safe_en           <= 1'b0;
      cfg_osc_source             <= 2'h3;
      cfg_external_clock_pin_io  <= 1'b0;
      cfg_external_rc_pin_io     <= 1'b0;
      cfg_crystal_mid_range_mode <= 1'b0;
      cfg_prog_mem_lock          <= 1'b0;
    end else begin
      cfg_clk_switch_en          <= !osc_w[`EDP_CLK_SW_HI];
      cfg_fail_safe_en           <= (osc_w[`EDP_CLK_SW_HI:`EDP_CLK_SW_LO] == 2'h0);
      cfg_osc_source             <= osc_w[`EDP_OSC_SRC_HI:`EDP_OSC_SRC_LO];
      // Other layouts keep these positions unknown here, so decode only variant 0
      cfg_external_clock_pin_io  <= (OSC_VARIANT == 0) && (pri_mode == 4'hF);
      cfg_external_rc_pin_io     <= (OSC_VARIANT == 0) && (pri_mode == 4'h8);
      cfg_crystal_mid_range_mode <= (OSC_VARIANT == 0) && (pri_mode == 4'h7);
      // Erased cell reads one, so protection is the programmed-zero state
      cfg_prog_mem_lock          <= !cfg_q[`EDP_CP_WORD][`EDP_CP_BIT];
    end
  end

  // AXI write channel: address and data taken in either order, response after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `EDP_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `EDP_RESP_OK : `EDP_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // AXI read channel: one cycle from address to data
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `EDP_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= map_ok(s_axi_araddr) ? `EDP_RESP_OK : `EDP_RESP_ERR;
      s_axi_rdata   <= 32'h00000000;
      if (s_axi_araddr == `EDP_OFF_ADDR)
        s_axi_rdata <= {16'h0000, addr_q};
      else if (s_axi_araddr == `EDP_OFF_STATUS)
        s_axi_rdata <= {29'h00000000, fail_q, done_q, !idle};
      else if (s_axi_araddr == `EDP_OFF_RDATA)
        s_axi_rdata <= {16'h0000, rb_q};
      else if (s_axi_araddr == `EDP_OFF_OSCDEC)
        s_axi_rdata <= {24'h000000, cfg_prog_mem_lock, cfg_crystal_mid_range_mode,
                        cfg_external_rc_pin_io, cfg_external_clock_pin_io, cfg_osc_source,
                        cfg_fail_safe_en, cfg_clk_switch_en};
      else if (s_axi_araddr[7:6] == `EDP_BASE_ROWBUF)
        s_axi_rdata <= {16'h0000, rowbuf_q[s_axi_araddr[5:2]]};
      else if (map_ok(s_axi_araddr) && (s_axi_araddr[7:5] == `EDP_BASE_CFG))
        s_axi_rdata <= {16'h0000, cfg_q[s_axi_araddr[4:2]]};
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** verification/edp_exec_sva.sv ***
// Purpose: Port checks for the EEPROM executive
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached by the bind at the foot
`timescale 1ns/1ns
`default_nettype none
module edp_exec_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cfg_clk_switch_en,
  input wire logic        cfg_fail_safe_en,
  input wire logic [1:0]  cfg_osc_source,
  input wire logic        cfg_external_clock_pin_io,
  input wire logic        cfg_external_rc_pin_io,
  input wire logic        cfg_crystal_mid_range_mode
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Both write channels taken together, and a response left waiting
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_held;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  wr_resp_a: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (b_held |=> s_axi_bvalid)
    else $error("write answer dropped");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer unstable");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  fail_safe_a: assert property (cfg_fail_safe_en |-> cfg_clk_switch_en)
    else $error("monitor without switching");
  pri_one_a: assert property ($onehot0({cfg_external_clock_pin_io, cfg_external_rc_pin_io,
    cfg_crystal_mid_range_mode}))
    else $error("two primary modes at once");
  // Source may only move after a write answer or a reset
  cfg_move_a: assert property (!$stable(cfg_osc_source) |-> $past(s_axi_bvalid)
    || $past(s_axi_bvalid, 2) || !$past(aresetn) || !$past(aresetn, 2))
    else $error("source moved without a write");
endmodule
bind edp_eeprom_exec edp_exec_sva chk (.*);
`default_nettype wire

// *** verification/edp_prog_model.sv ***
// Purpose: Programmer model that drives the register bus
// Assumes: One write and one read at a time
// Notes:   slow delays bready and rready so held answers are seen
`timescale 1ns/1ns
`default_nettype none
module edp_prog_model (
  input  wire logic        aclk,
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  int slow = 0;
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
  end
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (k = 0; k < 80; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (k >= slow) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k == 80) tb.hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (k = 0; k < 80; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (k >= slow) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (k == 80) tb.hang();
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the EEPROM executive
// Assumes: 100 MHz clock, smallest panel size
// Notes:   Read answers are matched against a queue of notes
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int NR = 32;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  wire logic [3:0] s_axi_wstrb = 4'hF;
  wire logic [7:0] s_axi_awaddr, s_axi_araddr;
  wire logic [31:0] s_axi_wdata, s_axi_rdata;
  wire logic [1:0] s_axi_bresp, s_axi_rresp, cfg_osc_source;
  wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire logic cfg_clk_switch_en, cfg_fail_safe_en, cfg_external_clock_pin_io;
  wire logic cfg_external_rc_pin_io, cfg_crystal_mid_range_mode, cfg_prog_mem_lock;
  logic [34:0] q[$];
  logic [34:0] e;
  logic [31:0] d;
  logic [15:0] v, v0, target_row_address, sum_b, sum_r;
  logic [15:0] img[NR * 16];
  logic [1:0] r;
  int n_fail = 0;
  int compares = 0;
  int i, j, rows_left_count;
  edp_eeprom_exec #(.ROWS(NR)) dut (.*);
  edp_prog_model pm (.*);
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang();
    n_fail++;
    $display("ERROR %0t wait ran out", $time);
    give_verdict();
  endtask
  task automatic cmp_rd(input logic [33:0] g, input logic [33:0] x);
    compares++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, g, x);
    end
  endtask
  task automatic cmp_lv(input logic [7:0] g, input logic [7:0] x);
    cmp_rd({26'h0, g}, {26'h0, x});
  endtask
  // Oldest note is matched to each read answer as it is taken
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && q.size() > 0) begin
      e = q.pop_front();
      if (e[34]) cmp_rd({s_axi_rresp, s_axi_rdata}, e[33:0]);
    end
  end
  task automatic w(input logic [7:0] ad, input logic [31:0] dd, input logic [1:0] er);
    pm.wr(ad, dd, r);
    cmp_lv({6'h0, r}, {6'h0, er});
  endtask
  task automatic x(input logic [7:0] ad, input logic [34:0] t);
    q.push_back(t);
    pm.rd(ad, d);
  endtask
  // Decodes settle a cycle behind the word, so allow a few edges; the decode register as well
  task automatic ck(input logic [15:0] c, input logic lk);
    logic [7:0] ex, gv;
    ex = {!c[15], c[15:14] == 2'h0, c[9:8], c[3:0] == 4'hF, c[3:0] == 4'h8, c[3:0] == 4'h7, lk};
    repeat (3) @(posedge aclk);
    gv = {cfg_clk_switch_en, cfg_fail_safe_en, cfg_osc_source, cfg_external_clock_pin_io,
      cfg_external_rc_pin_io, cfg_crystal_mid_range_mode, cfg_prog_mem_lock};
    cmp_lv(gv, ex);
    x(8'h10, {3'h4, 24'h0, ex[0], ex[1], ex[2], ex[3], ex[5:4], ex[6], ex[7]});
  endtask
  task automatic busy_wait();
    int k;
    repeat (2) @(posedge aclk);
    for (k = 0; k < 60; k++) begin
      x(8'h08, 35'h0);
      if (d[0] === 1'b0) break;
    end
    if (k == 60) hang();
  endtask
  initial begin
    void'($urandom(32'h586B));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    x(8'h80, 35'h4_0000_FFFF);
    w(8'h80, 32'h0000FFFF, 2'h0);
    ck(16'hFFFF, 1'b0);
    pm.slow = 3;
    // Every switch and source code, and each named primary mode
    for (i = 0; i < 8; i++) begin
      v0 = 16'($urandom);
      v0[15:14] = i[1:0];
      v0[9:8] = i[2:1];
      if (i < 6) v0[3:0] = (i % 3 == 0) ? 4'hF : ((i % 3 == 1) ? 4'h8 : 4'h7);
      w(8'h80, {16'h0, v0}, 2'h0);
      x(8'h80, {3'h4, 16'h0, v0});
      ck(v0, 1'b0);
    end
    for (j = 1; j < 7; j++) begin
      v = 16'($urandom);
      v[0] = j[0];
      w(8'h80 + 8'(4 * j), {16'h0, v}, 2'h0);
      x(8'h80 + 8'(4 * j), {3'h4, 16'h0, v});
    end
    ck(v0, 1'b1);
    pm.slow = 0;
    // Whole panel, one row command per row, advancing one row at a time
    rows_left_count = NR;
    target_row_address = 16'h0000;
    while (rows_left_count > 0) begin
      for (j = 0; j < 16; j++) begin
        img[target_row_address[15:1] + j] = 16'($urandom);
        w(8'h40 + 8'(4 * j), {16'h0, img[target_row_address[15:1] + j]}, 2'h0);
      end
      w(8'h04, {16'h0, target_row_address}, 2'h0);
      w(8'h00, 32'h1, 2'h0);
      w(8'h40, {16'h0, ~img[target_row_address[15:1]]}, 2'h0);
      busy_wait();
      x(8'h08, 35'h4_0000_0002);
      w(8'h08, 32'h6, 2'h0);
      // A reported failure ends the sequence; a full restart would need an erase
      if (d[2:0] !== 3'h2) break;
      rows_left_count--;
      if (rows_left_count > 0) target_row_address += 16'h0020;
    end
    // Every word read back against the bench's copy, with a running sum as a second check
    sum_b = 16'h0000;
    sum_r = 16'h0000;
    for (i = 0; i < NR * 16; i++) begin
      w(8'h04, {16'h0, 16'(2 * i)}, 2'h0);
      w(8'h00, 32'h2, 2'h0);
      x(8'h0C, {3'h4, 16'h0, img[i]});
      sum_b += img[i];
      sum_r += d[15:0];
    end
    cmp_rd({18'h0, sum_r}, {18'h0, sum_b});
    // Row command one row past the panel: nothing written, done and fail both set
    w(8'h08, 32'h6, 2'h0);
    w(8'h04, {16'h0, 16'(NR * 32)}, 2'h0);
    w(8'h00, 32'h1, 2'h0);
    busy_wait();
    x(8'h08, 35'h4_0000_0006);
    // Read-back past the panel and at an odd address: refused, word left as it was
    for (i = 0; i < 2; i++) begin
      w(8'h08, 32'h6, 2'h0);
      w(8'h04, {16'h0, (i == 0) ? 16'(NR * 32) : 16'h0001}, 2'h0);
      w(8'h00, 32'h2, 2'h0);
      x(8'h08, 35'h4_0000_0006);
      x(8'h0C, {3'h4, 16'h0, img[NR * 16 - 1]});
    end
    w(8'h9C, 32'h1, 2'h2);
    x(8'h9C, 35'h6_0000_0000);
    repeat (5) @(posedge aclk);
    give_verdict();
  end
endmodule
`default_nettype wire
